// [hdl/dac_mute_pkg.sv]
package dac_mute_pkg;

  // ----------------------------------------------------------------
  // bus and sample widths
  // ----------------------------------------------------------------
  localparam int unsigned WB_ADR_W = 12;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned WB_SEL_W = 4;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned IDX_MSB  = 9;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POWER  = 8'h3F;
  localparam logic [7:0] IDX_SETUP2 = 8'h40;
  localparam logic [7:0] IDX_LVOL   = 8'h41;
  localparam logic [7:0] IDX_RVOL   = 8'h42;
  localparam logic [7:0] IDX_STATUS = 8'h50;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned POW_LEFT_BIT  = 7;
  localparam int unsigned POW_RIGHT_BIT = 6;
  localparam int unsigned RMOD_SEL_BIT  = 7;
  localparam int unsigned AMUTE_MSB     = 6;
  localparam int unsigned AMUTE_LSB     = 4;
  localparam int unsigned LMUTE_BIT     = 3;
  localparam int unsigned RMUTE_BIT     = 2;
  localparam int unsigned LINK_MSB      = 1;
  localparam int unsigned LINK_LSB      = 0;
  localparam int unsigned STAT_AMUTE_BIT = 0;
  localparam int unsigned STAT_RUN_LSB   = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP2_RST = 8'h0C;
  localparam logic [7:0] VOL_RST    = 8'h00;
  localparam logic [1:0] POWER_RST  = 2'h0;

  // ----------------------------------------------------------------
  // modes and auto-mute run lengths
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_NONE     = 2'h0,
    LINK_L_FROM_R = 2'h1,
    LINK_R_FROM_L = 2'h2,
    LINK_RSVD     = 2'h3
  } link_mode_t;

  localparam int unsigned RUN_W          = 13;
  localparam logic [2:0]  AMUTE_OFF      = 3'h0;
  localparam logic [12:0] AMUTE_BASE_RUN = 13'h0064;

  // ----------------------------------------------------------------
  // volume: 12 half-dB steps per octave, mantissa in q1.15
  // ----------------------------------------------------------------
  localparam logic [8:0] VOL_OFFSET    = 9'h090;
  localparam logic [8:0] VOL_STEPS_OCT = 9'h00C;
  localparam logic [4:0] VOL_SHIFT_BASE = 5'h1B;
  localparam logic [11:0][15:0] MANT_TABLE = {
    16'hF11C, 16'hE39F, 16'hD6E3, 16'hCADE, 16'hBF85, 16'hB4CE,
    16'hAAB1, 16'hA125, 16'h9821, 16'h8F9E, 16'h8796, 16'h8000
  };

endpackage : dac_mute_pkg

// [hdl/dac_mute_volume_control.sv]
// Notes on behaviour
// [R1] right powered down with select 0: right modulator outputs zero
// [R2] right powered down with select 1: right gets inverted left output
// [R3] auto-mute field bits 6:4, reset 000, 000 disables auto-mute
// [R4] codes 001..100 mute after 100, 200, 400, 800 constant inputs
// [R5] codes 101..111 mute after 1600, 3200, 6400 constant inputs
// [R6] a changed sample restarts the run count and releases auto-mute
// [R7] bit 3 mutes left when 1, resets to 1
// [R8] bit 2 mutes right when 1, resets to 1
// [R9] link field 00, reset value: each channel uses its own volume
// [R10] link field 01: left uses the right volume setting
// [R11] link field 10: right uses the left volume setting
// [R12] software must not write link code 11
// [R13] volume code is two's complement, half dB steps, up to +24dB
// [R14] code zero, the reset value, gives unity gain
// [R15] negative codes attenuate down to -63.5dB at 1000 0001
// [R16] software must not write codes 0x31..0x7F or 0x80
// [R17] right volume register uses the same coding and resets to zero
// [R18] per channel power bit, 1 up, 0 down, steers right modulator
`timescale 1ns/1ns
`default_nettype none
module dac_mute_volume_control
  import dac_mute_pkg::*;
#(
  parameter int unsigned W = SAMPLE_W
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [WB_SEL_W-1:0] wb_sel_i,
  input  wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic      [WB_DAT_W-1:0] wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                smp_valid_i,
  input  wire logic [W-1:0]        smp_left_i,
  input  wire logic [W-1:0]        smp_right_i,
  output logic      [W-1:0]        dac_left_o,
  output logic      [W-1:0]        dac_right_o,
  output logic                     dac_valid_o,
  output logic                     auto_muted_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                ack;
    logic [WB_DAT_W-1:0] rdata;
    logic [1:0]          power;
    logic [REG_W-1:0]    setup;
    logic [REG_W-1:0]    lvol;
    logic [REG_W-1:0]    rvol;
    logic [W-1:0]        prev_l;
    logic [W-1:0]        prev_r;
    logic                prev_ok;
    logic [RUN_W-1:0]    run;
    logic                amute;
    logic [W-1:0]        out_l;
    logic [W-1:0]        out_r;
    logic                out_v;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic       [W-1:0] scaled_l;
  logic       [W-1:0] scaled_r;
  logic       [7:0]   code_l;
  logic       [7:0]   code_r;
  link_mode_t         link;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [RUN_W-1:0] run_limit(input logic [2:0] code);
    logic [2:0] k;
    k = code - 3'h1;
    // [R4] doubling run lengths
    // [R5] upper codes continue doubling
    run_limit = AMUTE_BASE_RUN << k;
  endfunction : run_limit

  function automatic logic [W-1:0] neg_sat(input logic [W-1:0] v);
    // most negative value has no positive twin; clip it
    if (v == {1'b1, {(W - 1){1'b0}}}) begin
      neg_sat = {1'b0, {(W - 1){1'b1}}};
    end else begin
      neg_sat = W'(-$signed(v));
    end
  endfunction : neg_sat

  // ----------------------------------------------------------------
  // volume selection and scaling
  // ----------------------------------------------------------------
  always_comb begin
    link   = link_mode_t'(s_r.setup[LINK_MSB:LINK_LSB]);
    code_l = s_r.lvol;
    code_r = s_r.rvol;
    unique case (link)
      // [R9] independent volumes
      LINK_NONE: begin
        code_l = s_r.lvol;
        code_r = s_r.rvol;
      end
      // [R10] left follows right
      LINK_L_FROM_R: begin
        code_l = s_r.rvol;
        code_r = s_r.rvol;
      end
      // [R11] right follows left
      LINK_R_FROM_L: begin
        code_l = s_r.lvol;
        code_r = s_r.lvol;
      end
      // [R12] reserved code falls back to independent
      LINK_RSVD: begin
        code_l = s_r.lvol;
        code_r = s_r.rvol;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // per-channel gain stage
  // ----------------------------------------------------------------
  logic [1:0][W-1:0] chan_in;
  logic [1:0][W-1:0] chan_scaled;
  logic [1:0][7:0]   chan_code;

  assign chan_in[0]   = smp_left_i;
  assign chan_in[1]   = smp_right_i;
  assign chan_code[0] = code_l;
  assign chan_code[1] = code_r;
  assign scaled_l     = chan_scaled[0];
  assign scaled_r     = chan_scaled[1];

  // [R14] zero code is unity gain
  // [R17] same coding on the right
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    vol_scale #(
      .W (W)
    ) u_scale (
      .sample_i (chan_in[ch]),
      .code_i   (chan_code[ch]),
      .sample_o (chan_scaled[ch])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic             req;
  logic [7:0]       idx;
  logic             wr;
  logic             same;
  logic [RUN_W-1:0] run_new;
  logic             am_new;
  logic [2:0]       am_code;
  logic [W-1:0]     left_new;
  logic [W-1:0]     right_new;

  always_comb begin
    s_nxt     = s_r;
    req       = wb_cyc_i & wb_stb_i;
    idx       = wb_adr_i[IDX_MSB:IDX_LSB];
    wr        = req & s_r.ack & wb_we_i & wb_sel_i[0];
    am_code   = s_r.setup[AMUTE_MSB:AMUTE_LSB];
    same      = 1'b0;
    run_new   = s_r.run;
    am_new    = s_r.amute;
    left_new  = s_r.out_l;
    right_new = s_r.out_r;

    // single wait state: ack one cycle after the strobe, dropped after
    s_nxt.ack = req & ~s_r.ack;
    if (req & ~s_r.ack) begin
      unique case (idx)
        IDX_POWER: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[POW_LEFT_BIT]  = s_r.power[1];
          s_nxt.rdata[POW_RIGHT_BIT] = s_r.power[0];
        end
        IDX_SETUP2: begin
          s_nxt.rdata = WB_DAT_W'(s_r.setup);
        end
        IDX_LVOL: begin
          s_nxt.rdata = WB_DAT_W'(s_r.lvol);
        end
        IDX_RVOL: begin
          s_nxt.rdata = WB_DAT_W'(s_r.rvol);
        end
        IDX_STATUS: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[STAT_AMUTE_BIT] = s_r.amute;
          s_nxt.rdata[STAT_RUN_LSB +: RUN_W] = s_r.run;
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    // writes land on the edge where the master sees ack
    if (wr) begin
      unique case (idx)
        // [R18] channel power bits
        IDX_POWER: begin
          s_nxt.power = {wb_dat_i[POW_LEFT_BIT], wb_dat_i[POW_RIGHT_BIT]};
        end
        IDX_SETUP2: begin
          s_nxt.setup = wb_dat_i[REG_W-1:0];
        end
        IDX_LVOL: begin
          s_nxt.lvol = wb_dat_i[REG_W-1:0];
        end
        IDX_RVOL: begin
          s_nxt.rvol = wb_dat_i[REG_W-1:0];
        end
        default: begin
          s_nxt.power = s_r.power;
        end
      endcase
    end

    s_nxt.out_v = smp_valid_i;
    if (smp_valid_i) begin
      same = s_r.prev_ok & (smp_left_i == s_r.prev_l) & (smp_right_i == s_r.prev_r);
      // [R6] changed sample restarts run
      if (!same) begin
        run_new = '0;
      end else if (run_new != {RUN_W{1'b1}}) begin
        run_new = s_r.run + 1'b1;
      end
      // [R3] field 000 disables auto-mute
      if (am_code == AMUTE_OFF) begin
        am_new = 1'b0;
      end else begin
        // [R4] mute once the run count reaches the run length
        am_new = (run_new >= run_limit(am_code));
      end

      // [R7] left manual mute
      if (!s_r.power[1] || s_r.setup[LMUTE_BIT] || am_new) begin
        left_new = '0;
      end else begin
        left_new = scaled_l;
      end

      // [R18] right modulator steered by power
      if (s_r.power[0]) begin
        // [R8] right manual mute
        if (s_r.setup[RMUTE_BIT] || am_new) begin
          right_new = '0;
        end else begin
          right_new = scaled_r;
        end
      end else if (s_r.setup[RMOD_SEL_BIT]) begin
        // [R2] inverted left for differential mono
        right_new = neg_sat(left_new);
      end else begin
        // [R1] zero when powered down
        right_new = '0;
      end

      s_nxt.prev_l  = smp_left_i;
      s_nxt.prev_r  = smp_right_i;
      s_nxt.prev_ok = 1'b1;
      s_nxt.run     = run_new;
      s_nxt.amute   = am_new;
      s_nxt.out_l   = left_new;
      s_nxt.out_r   = right_new;
    end

    // a mode change to off releases mute without waiting for a sample
    if (am_code == AMUTE_OFF) begin
      s_nxt.amute = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r.ack     <= 1'b0;
      s_r.rdata   <= '0;
      s_r.power   <= POWER_RST;
      s_r.setup   <= SETUP2_RST;
      s_r.lvol    <= VOL_RST;
      s_r.rvol    <= VOL_RST;
      s_r.prev_l  <= '0;
      s_r.prev_r  <= '0;
      s_r.prev_ok <= 1'b0;
      s_r.run     <= '0;
      s_r.amute   <= 1'b0;
      s_r.out_l   <= '0;
      s_r.out_r   <= '0;
      s_r.out_v   <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o     = s_r.rdata;
  assign wb_ack_o     = s_r.ack;
  assign dac_left_o   = s_r.out_l;
  assign dac_right_o  = s_r.out_r;
  assign dac_valid_o  = s_r.out_v;
  assign auto_muted_o = s_r.amute;

endmodule : dac_mute_volume_control
`default_nettype wire

// [hdl/vol_scale.sv]
`timescale 1ns/1ns
`default_nettype none
module vol_scale
  import dac_mute_pkg::*;
#(
  parameter int unsigned W = SAMPLE_W
) (
  input  wire logic [W-1:0] sample_i,
  input  wire logic [7:0]   code_i,
  output logic      [W-1:0] sample_o
);

  logic        [8:0]    c;
  logic        [4:0]    q;
  logic        [3:0]    r;
  logic        [4:0]    sh;
  logic signed [W+16:0] prod;
  logic signed [W+31:0] ext;
  logic signed [W+31:0] res;
  logic signed [W+31:0] hi;
  logic signed [W+31:0] lo;

  always_comb begin
    // code plus offset is always positive, so wrap in 9 bits is safe
    c    = {code_i[7], code_i} + VOL_OFFSET;
    q    = 5'(c / VOL_STEPS_OCT);
    r    = 4'(c % VOL_STEPS_OCT);
    sh   = VOL_SHIFT_BASE - q;
    // [R13] two's complement gain
    // [R15] attenuation in half dB
    prod = $signed(sample_i) * $signed({1'b0, MANT_TABLE[r]});
    ext  = (W + 32)'(prod);
    res  = ext >>> sh;
    hi   = (W + 32)'($signed({1'b0, {(W - 1){1'b1}}}));
    lo   = (W + 32)'($signed({1'b1, {(W - 1){1'b0}}}));
    // gain above unity may overflow; clip rather than wrap
    if (res > hi) begin
      sample_o = {1'b0, {(W - 1){1'b1}}};
    end else if (res < lo) begin
      sample_o = {1'b1, {(W - 1){1'b0}}};
    end else begin
      sample_o = res[W-1:0];
    end
  end

endmodule : vol_scale
`default_nettype wire

// [verification/dac_mute_volume_control_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module dac_mute_volume_control_assertions
  import dac_mute_pkg::*;
#(
  parameter int unsigned W = SAMPLE_W
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [WB_SEL_W-1:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  input wire logic                wb_ack_o,
  input wire logic                smp_valid_i,
  input wire logic [W-1:0]        smp_left_i,
  input wire logic [W-1:0]        smp_right_i,
  input wire logic [W-1:0]        dac_left_o,
  input wire logic [W-1:0]        dac_right_o,
  input wire logic                dac_valid_o,
  input wire logic                auto_muted_o
);
  // ----------------------------------------------------------------
  // shadow of settings, taken from acked writes
  // ----------------------------------------------------------------
  logic [7:0]   setup_r;
  logic [7:0]   pow_r;
  logic [W-1:0] pl_r;
  logic [W-1:0] pr_r;
  logic         have_r;
  logic [12:0]  run_r;
  logic         due_r;
  wire logic        wr_ok   = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire logic [7:0]  idx     = wb_adr_i[IDX_MSB:IDX_LSB];
  wire logic        same    = have_r && smp_left_i == pl_r && smp_right_i == pr_r;
  wire logic [12:0] run_nxt = same ? (&run_r ? run_r : run_r + 13'h1) : 13'h0;
  wire logic [15:0] lim     = 16'(AMUTE_BASE_RUN) << (setup_r[6:4] - 3'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_r <= SETUP2_RST;
      pow_r   <= 8'h00;
      have_r  <= 1'b0;
      run_r   <= 13'h0;
      due_r   <= 1'b0;
    end else begin
      if (wr_ok && idx == IDX_SETUP2) setup_r <= wb_dat_i[7:0];
      if (wr_ok && idx == IDX_POWER) pow_r <= wb_dat_i[7:0];
      if (smp_valid_i) begin
        have_r <= 1'b1;
        pl_r   <= smp_left_i;
        pr_r   <= smp_right_i;
        run_r  <= run_nxt;
        due_r  <= {3'h0, run_nxt} >= lim;
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  AST_VALID_ON: assert property (smp_valid_i |=> dac_valid_o)
    else $error("no output valid after sample");
  AST_VALID_OFF: assert property (!smp_valid_i |=> !dac_valid_o)
    else $error("output valid without sample");
  AST_RIGHT_ZERO: assert property (
    smp_valid_i && !pow_r[6] && !setup_r[7] |=> dac_right_o == '0) else $error("right not zero");
  AST_RIGHT_INV: assert property (
    smp_valid_i && !pow_r[6] && setup_r[7] |=> dac_right_o == ((dac_left_o == {1'b1, {(W-1){1'b0}}}) ?
    {1'b0, {(W-1){1'b1}}} : -dac_left_o)) else $error("right not inverted left");
  AST_LEFT_MUTE: assert property (smp_valid_i && setup_r[3] |=> dac_left_o == '0)
    else $error("left mute ignored");
  AST_RIGHT_MUTE: assert property (smp_valid_i && pow_r[6] && setup_r[2] |=> dac_right_o == '0)
    else $error("right mute ignored");
  AST_LEFT_DOWN: assert property (smp_valid_i && !pow_r[7] |=> dac_left_o == '0)
    else $error("left down but not zero");
  AST_AMUTE_OFF: assert property (setup_r[6:4] == AMUTE_OFF |=> !auto_muted_o)
    else $error("auto mute while disabled");
  AST_AMUTE_RUN: assert property (
    smp_valid_i && setup_r[6:4] != AMUTE_OFF |=> auto_muted_o == due_r) else $error("auto mute count wrong");
  AST_AMUTE_REL: assert property (smp_valid_i && !same |=> !auto_muted_o)
    else $error("auto mute kept on changed data");
endmodule : dac_mute_volume_control_assertions
`default_nettype wire

// [verification/dac_mute_volume_control_test.sv]
`timescale 1ns/1ns
`default_nettype none
module dac_mute_volume_control_test;
  import dac_mute_pkg::*;
  logic                clk_i  = 1'b0;
  logic                rst_i  = 1'b1;
  logic                cyc    = 1'b0;
  logic                stb    = 1'b0;
  logic                we     = 1'b0;
  logic [WB_ADR_W-1:0] adr    = '0;
  logic [WB_SEL_W-1:0] sel    = '0;
  logic [WB_DAT_W-1:0] dat_w  = '0;
  logic [WB_DAT_W-1:0] dat_r;
  logic                ack;
  logic                valid;
  logic                dvalid;
  logic                amuted;
  logic [SAMPLE_W-1:0] sl;
  logic [SAMPLE_W-1:0] sr;
  logic [SAMPLE_W-1:0] dl;
  logic [SAMPLE_W-1:0] dr;
  int                  err_total    = 0;
  int                  total_checks = 0;

  always #5 clk_i = ~clk_i;

  dac_mute_volume_control u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .smp_valid_i(valid), .smp_left_i(sl), .smp_right_i(sr), .dac_left_o(dl),
    .dac_right_o(dr), .dac_valid_o(dvalid), .auto_muted_o(amuted)
  );
  sample_source u_src (.clk_i(clk_i), .valid_o(valid), .left_o(sl), .right_o(sr));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // request held until ack is sampled high, released at that edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= 4'hF;
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    chk("ack", 32'h1, {31'h0, ack});
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask : rd

  task automatic smp(input logic [15:0] l, input logic [15:0] r, input logic [15:0] el, input logic [15:0] er);
    u_src.send(l, r);
    #1;
    chk("valid", 32'h1, {31'h0, dvalid});
    chk("left", {16'h0, el}, {16'h0, dl});
    chk("right", {16'h0, er}, {16'h0, dr});
  endtask : smp

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(12'h0FC, 32'h00, "power");
    rd(12'h100, 32'h0C, "setup");
    rd(12'h104, 32'h00, "lvol");
    rd(12'h108, 32'h00, "rvol");
    wr(12'h10C, 8'h5A);
    rd(12'h10C, 32'h00, "unmapped");
  endtask : t_reset

  // power-of-two steps are exact; codes 01 and 81 expect values from the mantissa table
  task automatic t_volume();
    logic [7:0]  code[7] = '{8'h00, 8'h01, 8'h0C, 8'hF4, 8'h30, 8'h81, 8'h30};
    logic [15:0] vin[7]  = '{16'h1000, 16'h1000, 16'h1000, 16'h1000, 16'h0100, 16'h7FFF, 16'hF000};
    logic [15:0] vexp[7] = '{16'h1000, 16'h10F2, 16'h2000, 16'h0800, 16'h1000, 16'h0015, 16'h8000};
    wr(12'h0FC, 8'hC0);
    wr(12'h100, 8'h00);
    foreach (code[i]) begin
      wr(12'h104, code[i]);
      wr(12'h108, code[i]);
      rd(12'h104, {24'h0, code[i]}, "lvol");
      rd(12'h108, {24'h0, code[i]}, "rvol");
      smp(vin[i], vin[i], vexp[i], vexp[i]);
    end
  endtask : t_volume

  task automatic t_link();
    logic [15:0] el[3] = '{16'h2000, 16'h0800, 16'h2000};
    logic [15:0] er[3] = '{16'h0800, 16'h0800, 16'h2000};
    wr(12'h104, 8'h0C);
    wr(12'h108, 8'hF4);
    for (int m = 0; m < 3; m++) begin
      wr(12'h100, 8'(m));
      smp(16'h1000, 16'h1000, el[m], er[m]);
    end
  endtask : t_link

  task automatic t_power();
    logic [7:0]  pw[5] = '{8'hC0, 8'hC0, 8'h80, 8'h80, 8'h40};
    logic [7:0]  st[5] = '{8'h08, 8'h04, 8'h80, 8'h00, 8'h00};
    logic [15:0] el[5] = '{16'h0000, 16'h1000, 16'h1000, 16'h1000, 16'h0000};
    logic [15:0] er[5] = '{16'h1000, 16'h0000, 16'hF000, 16'h0000, 16'h1000};
    wr(12'h104, 8'h00);
    wr(12'h108, 8'h00);
    foreach (pw[i]) begin
      wr(12'h0FC, pw[i]);
      wr(12'h100, st[i]);
      smp(16'h1000, 16'h1000, el[i], er[i]);
    end
  endtask : t_power

  task automatic t_auto();
    int          n;
    logic [15:0] v;
    wr(12'h0FC, 8'hC0);
    for (int c = 1; c < 8; c++) begin
      n = 100 << (c - 1);
      v = 16'h0200 + 16'(c);
      wr(12'h100, {1'b0, 3'(c), 4'h0});
      for (int k = 0; k < n; k++) smp(v, v, v, v);
      smp(v, v, 16'h0000, 16'h0000);
      chk("amute", 32'h1, {31'h0, amuted});
      rd(12'h140, {3'h0, 13'(n), 15'h0, 1'b1}, "status");
      if (c < 7) begin
        smp(~v, v, ~v, v);
        chk("amute", 32'h0, {31'h0, amuted});
      end
    end
    wr(12'h100, 8'h00);
    repeat (2) @(posedge clk_i);
    #1;
    chk("amute", 32'h0, {31'h0, amuted});
  endtask : t_auto

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_volume();
    t_link();
    t_power();
    t_auto();
    end_sim();
  end

  // about 26k cycles expected; 60k means a hang
  initial begin
    #600000;
    err_total++;
    end_sim();
  end
endmodule : dac_mute_volume_control_test

bind dac_mute_volume_control dac_mute_volume_control_assertions #(.W(W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .smp_valid_i(smp_valid_i), .smp_left_i(smp_left_i), .smp_right_i(smp_right_i),
  .dac_left_o(dac_left_o), .dac_right_o(dac_right_o), .dac_valid_o(dac_valid_o),
  .auto_muted_o(auto_muted_o)
);
`default_nettype wire

// [verification/sample_source.sv]
`timescale 1ns/1ns
`default_nettype none
module sample_source
  import dac_mute_pkg::*;
(
  input  wire logic                clk_i,
  output logic                     valid_o,
  output logic      [SAMPLE_W-1:0] left_o,
  output logic      [SAMPLE_W-1:0] right_o
);
  // ----------------------------------------------------------------
  // word clock source
  // ----------------------------------------------------------------
  initial begin
    valid_o = 1'b0;
    left_o  = 16'h5555;
    right_o = 16'hAAAA;
  end

  // one pair per call; released lines carry the inverse, never stale words
  task automatic send(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
    @(posedge clk_i);
    valid_o <= 1'b1;
    left_o  <= l;
    right_o <= r;
    @(posedge clk_i);
    valid_o <= 1'b0;
    left_o  <= ~l;
    right_o <= ~r;
  endtask : send
endmodule : sample_source
`default_nettype wire
